// *** core/lane_mask.sv ***
`timescale 1ns/1ns
`default_nettype none
module lane_mask (
  input  wire wlm_pkg::org_e                org,
  input  wire logic [wlm_pkg::LANES-1:0]    bws_n,
  input  wire logic [1:0]                   nws_n,
  output logic      [wlm_pkg::DATA_W-1:0]   mask
);

  logic [wlm_pkg::DATA_W-1:0] lane_bits;

  // One nine-bit lane per select; active lane count follows organization
  for (genvar i = 0; i < wlm_pkg::LANES; i++) begin : g_lane
    logic en;
    always_comb begin
      case (org)
        wlm_pkg::ORG_X36: en = ~bws_n[i];
        wlm_pkg::ORG_X18: en = (i < 2) && !bws_n[i];
        wlm_pkg::ORG_X9:  en = (i == 0) && !bws_n[i];
        default:          en = 1'b0;
      endcase
    end
    assign lane_bits[i*wlm_pkg::LANE_W +: wlm_pkg::LANE_W] = {wlm_pkg::LANE_W{en}};
  end

  // Byte-wide part uses nibble selects instead
  always_comb begin
    if (org == wlm_pkg::ORG_X8) begin
      mask = '0;
      mask[wlm_pkg::NIB_W-1:0]              = {wlm_pkg::NIB_W{~nws_n[0]}};
      mask[2*wlm_pkg::NIB_W-1:wlm_pkg::NIB_W] = {wlm_pkg::NIB_W{~nws_n[1]}};
    end else begin
      mask = lane_bits;
    end
  end

endmodule : lane_mask
`default_nettype wire

// *** core/pin_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire wlm_pkg::pins_s d,
  output var  wlm_pkg::pins_s q
);

  wlm_pkg::pins_s meta_q;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= wlm_pkg::PINS_RST;
      q      <= wlm_pkg::PINS_RST;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : pin_sync
`default_nettype wire

// *** core/wlm_pkg.sv ***
package wlm_pkg;

  // Array word and lane geometry
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int LANES  = 4;
  localparam int NIB_W  = 4;
  localparam int ADDR_W = 4;
  localparam int DEPTH  = 16;
  localparam int WORD_W = 2 * DATA_W;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] RDADDR_OFF = 8'h08;
  localparam logic [7:0] RDDATA_OFF = 8'h0c;

  // Field positions
  localparam int CTRL_ORG_LSB   = 0;
  localparam int CTRL_EN_BIT    = 2;
  localparam int RDADDR_SEL_LSB = 4;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_CNT_LSB   = 16;

  // Organization of the write word
  typedef enum logic [1:0] {
    ORG_X8  = 2'b00,
    ORG_X9  = 2'b01,
    ORG_X18 = 2'b10,
    ORG_X36 = 2'b11
  } org_e;

  // Write port sequencing
  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_BEAT1 = 1'b1
  } wr_state_e;

  // Values after reset
  localparam org_e       ORG_RST = ORG_X36;
  localparam logic       EN_RST  = 1'b1;
  localparam logic [15:0] CNT_RST = 16'h0000;

  // Write port pins travelling together
  typedef struct packed {
    logic              k_pos;
    logic              k_neg;
    logic              sel_n;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  bws_n;
    logic [1:0]        nws_n;
    logic [DATA_W-1:0] data;
  } pins_s;

  // Pins idle high: clocks stopped high, port deselected
  localparam pins_s PINS_RST = '1;

endpackage : wlm_pkg

// *** core/write_lane_mask.sv ***
`timescale 1ns/1ns
`default_nettype none
module write_lane_mask (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic      [31:0]                 hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  input  wire logic                        input_timing_pos,
  input  wire logic                        input_timing_neg,
  input  wire logic                        wr_port_sel_n,
  input  wire logic [wlm_pkg::ADDR_W-1:0]  wr_addr_in,
  input  wire logic [wlm_pkg::LANES-1:0]   lane_write_select_n,
  input  wire logic [1:0]                  half_lane_write_select_n,
  input  wire logic [wlm_pkg::DATA_W-1:0]  wr_bus_in,
  output logic                             rd_bus_oe,
  output logic                             wr_busy
);

  wlm_pkg::pins_s             pins_raw;
  wlm_pkg::pins_s             pins;
  logic                       pos_prev_q;
  logic                       neg_prev_q;
  logic                       pos_rise;
  logic                       neg_rise;
  logic [wlm_pkg::DATA_W-1:0] cur_mask;
  wlm_pkg::wr_state_e         state_q;
  logic [wlm_pkg::DATA_W-1:0] lo_data_q;
  logic [wlm_pkg::DATA_W-1:0] lo_mask_q;
  logic                       commit_q;
  logic [wlm_pkg::ADDR_W-1:0] waddr_q;
  logic [wlm_pkg::WORD_W-1:0] wmask_q;
  logic [wlm_pkg::WORD_W-1:0] wnew_q;
  logic [wlm_pkg::WORD_W-1:0] wold_q;
  logic [wlm_pkg::WORD_W-1:0] new_word;
  logic [wlm_pkg::WORD_W-1:0] new_mask;
  logic [wlm_pkg::WORD_W-1:0] mem [wlm_pkg::DEPTH];
  logic [15:0]                cnt_q;
  wlm_pkg::org_e              org_q;
  logic                       en_q;
  logic [wlm_pkg::ADDR_W-1:0] rd_addr_q;
  logic [1:0]                 rd_sel_q;
  logic                       ap;
  logic                       dp_wr_q;
  logic                       dp_rd_q;
  logic [7:0]                 dp_addr_q;
  logic [31:0]                rd_mux;
  logic [wlm_pkg::WORD_W-1:0] rd_word;
  logic [wlm_pkg::WORD_W-1:0] org_span;

  // Pin bundle into the bus clock domain
  assign pins_raw = '{k_pos: input_timing_pos, k_neg: input_timing_neg, sel_n: wr_port_sel_n,
                      addr: wr_addr_in, bws_n: lane_write_select_n,
                      nws_n: half_lane_write_select_n, data: wr_bus_in};

  pin_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (pins_raw),
    .q       (pins)
  );

  // Rising edges of the two write clocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_prev_q <= 1'b1;
      neg_prev_q <= 1'b1;
    end else begin
      pos_prev_q <= pins.k_pos;
      neg_prev_q <= pins.k_neg;
    end
  end

  assign pos_rise = pins.k_pos & ~pos_prev_q;
  assign neg_rise = pins.k_neg & ~neg_prev_q;

  // Per-beat lane enables from the current selects
  lane_mask u_mask (
    .org   (org_q),
    .bws_n (pins.bws_n),
    .nws_n (pins.nws_n),
    .mask  (cur_mask)
  );

  // Write burst sequencing; request only honoured while idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= wlm_pkg::ST_IDLE;
    end else begin
      case (state_q)
        wlm_pkg::ST_IDLE: begin
          if (pos_rise && !pins.sel_n && en_q) begin
            state_q <= wlm_pkg::ST_BEAT1;
          end
        end
        wlm_pkg::ST_BEAT1: begin
          if (neg_rise) begin
            state_q <= wlm_pkg::ST_IDLE;
          end
        end
        default: state_q <= wlm_pkg::ST_IDLE;
      endcase
    end
  end

  // Lower beat and its own lane pattern
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lo_data_q <= '0;
      lo_mask_q <= '0;
    end else if (state_q == wlm_pkg::ST_IDLE && pos_rise && !pins.sel_n && en_q) begin
      lo_data_q <= pins.data;
      lo_mask_q <= cur_mask;
    end
  end

  // Upper beat joins lower beat; masks kept apart per beat
  assign new_word = {pins.data, lo_data_q};
  assign new_mask = {cur_mask, lo_mask_q};

  // Commit record: address, mask, old and new contents
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      commit_q <= 1'b0;
      waddr_q  <= '0;
      wmask_q  <= '0;
      wnew_q   <= '0;
      wold_q   <= '0;
    end else begin
      commit_q <= (state_q == wlm_pkg::ST_BEAT1) && neg_rise;
      if (state_q == wlm_pkg::ST_BEAT1 && neg_rise) begin
        waddr_q <= pins.addr;
        wmask_q <= new_mask;
        wnew_q  <= new_word;
        wold_q  <= mem[pins.addr];
      end
    end
  end

  // Array write merges only enabled lanes into the old word
  always_ff @(posedge hclk) begin
    if (state_q == wlm_pkg::ST_BEAT1 && neg_rise) begin
      mem[pins.addr] <= (mem[pins.addr] & ~new_mask) | (new_word & new_mask);
    end
  end

  // Completed burst counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= wlm_pkg::CNT_RST;
    end else if (commit_q) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Pin-facing status; read path absent so data outputs stay released
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_bus_oe <= 1'b0;
      wr_busy   <= 1'b0;
    end else begin
      rd_bus_oe <= 1'b0;
      wr_busy   <= (state_q == wlm_pkg::ST_BEAT1);
    end
  end

  // Bus address phase capture
  assign ap = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q   <= 1'b0;
      dp_rd_q   <= 1'b0;
      dp_addr_q <= '0;
    end else begin
      dp_wr_q <= ap && hwrite;
      dp_rd_q <= ap && !hwrite;
      if (ap) begin
        dp_addr_q <= haddr[7:0];
      end
    end
  end

  // Register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      org_q     <= wlm_pkg::ORG_RST;
      en_q      <= wlm_pkg::EN_RST;
      rd_addr_q <= '0;
      rd_sel_q  <= '0;
    end else if (dp_wr_q) begin
      if (dp_addr_q == wlm_pkg::CTRL_OFF) begin
        org_q <= wlm_pkg::org_e'(hwdata[wlm_pkg::CTRL_ORG_LSB +: 2]);
        en_q  <= hwdata[wlm_pkg::CTRL_EN_BIT];
      end
      if (dp_addr_q == wlm_pkg::RDADDR_OFF) begin
        rd_addr_q <= hwdata[wlm_pkg::ADDR_W-1:0];
        rd_sel_q  <= hwdata[wlm_pkg::RDADDR_SEL_LSB +: 2];
      end
    end
  end

  // Read multiplexer; unmapped offsets read zero
  assign rd_word = mem[rd_addr_q];

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (dp_addr_q)
      wlm_pkg::CTRL_OFF: begin
        rd_mux[wlm_pkg::CTRL_ORG_LSB +: 2] = org_q;
        rd_mux[wlm_pkg::CTRL_EN_BIT]       = en_q;
      end
      wlm_pkg::STATUS_OFF: begin
        rd_mux[wlm_pkg::STAT_BUSY_BIT]      = (state_q == wlm_pkg::ST_BEAT1);
        rd_mux[wlm_pkg::STAT_CNT_LSB +: 16] = cnt_q;
      end
      wlm_pkg::RDADDR_OFF: begin
        rd_mux[wlm_pkg::ADDR_W-1:0]         = rd_addr_q;
        rd_mux[wlm_pkg::RDADDR_SEL_LSB +: 2] = rd_sel_q;
      end
      wlm_pkg::RDDATA_OFF: begin
        case (rd_sel_q)
          2'h0:    rd_mux = rd_word[31:0];
          2'h1:    rd_mux = {28'h0000000, rd_word[35:32]};
          2'h2:    rd_mux = rd_word[67:36];
          default: rd_mux = {28'h0000000, rd_word[71:68]};
        endcase
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Reads take one wait state so a preceding write is visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= !(ap && !hwrite);
      hresp     <= 1'b0;
      if (dp_rd_q) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Bits the organization can ever hold; the rest of the array stays unknown
  always_comb begin
    case (org_q)
      wlm_pkg::ORG_X8:  org_span = {2{36'h0000000ff}};
      wlm_pkg::ORG_X9:  org_span = {2{36'h0000001ff}};
      wlm_pkg::ORG_X18: org_span = {2{36'h00003ffff}};
      default:          org_span = {2{36'hfffffffff}};
    endcase
  end

  // Checks on beat capture, lane merging and released data outputs
  a_first_beat_taken: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == wlm_pkg::ST_IDLE && pos_rise && !pins.sel_n && en_q)
      |=> (state_q == wlm_pkg::ST_BEAT1 && lo_data_q == $past(pins.data)))
    else $error("first beat not captured");

  a_second_beat_commit: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == wlm_pkg::ST_BEAT1 && neg_rise)
      |=> (commit_q && waddr_q == $past(pins.addr) && wnew_q[71:36] == $past(pins.data)))
    else $error("second beat or address not committed");

  a_lane_kept: assert property (@(posedge hclk) disable iff (!hresetn)
    commit_q |-> (((mem[waddr_q] ^ wold_q) & ~wmask_q & org_span) == '0))
    else $error("unselected lane altered");

  a_lane_stored: assert property (@(posedge hclk) disable iff (!hresetn)
    commit_q |-> (((mem[waddr_q] ^ wnew_q) & wmask_q) == '0))
    else $error("selected lane not stored");

  a_x8_full: assert property (@(posedge hclk) disable iff (!hresetn)
    (org_q == wlm_pkg::ORG_X8 && pins.nws_n == 2'b00) |-> cur_mask == 36'h0000000ff)
    else $error("byte mode full mask wrong");

  a_x8_nibble: assert property (@(posedge hclk) disable iff (!hresetn)
    (org_q == wlm_pkg::ORG_X8 && pins.nws_n[0] != pins.nws_n[1])
      |-> cur_mask == (pins.nws_n[0] ? 36'h0000000f0 : 36'h00000000f))
    else $error("byte mode nibble mask wrong");

  a_x18_full: assert property (@(posedge hclk) disable iff (!hresetn)
    (org_q == wlm_pkg::ORG_X18 && pins.bws_n[1:0] == 2'b00) |-> cur_mask == 36'h00003ffff)
    else $error("eighteen-bit full mask wrong");

  a_x18_lane: assert property (@(posedge hclk) disable iff (!hresetn)
    (org_q == wlm_pkg::ORG_X18 && pins.bws_n[0] != pins.bws_n[1])
      |-> cur_mask == (pins.bws_n[0] ? 36'h00003fe00 : 36'h0000001ff))
    else $error("eighteen-bit lane mask wrong");

  a_narrow_none: assert property (@(posedge hclk) disable iff (!hresetn)
    ((org_q == wlm_pkg::ORG_X8 && pins.nws_n == 2'b11)
     || (org_q == wlm_pkg::ORG_X18 && pins.bws_n[1:0] == 2'b11)) |-> cur_mask == '0)
    else $error("nothing should be stored");

  a_x9_select: assert property (@(posedge hclk) disable iff (!hresetn)
    (org_q == wlm_pkg::ORG_X9)
      |-> cur_mask == (pins.bws_n[0] ? 36'h000000000 : 36'h0000001ff))
    else $error("nine-bit mask wrong");

  a_x36_full: assert property (@(posedge hclk) disable iff (!hresetn)
    (org_q == wlm_pkg::ORG_X36 && pins.bws_n == 4'h0) |-> cur_mask == 36'hfffffffff)
    else $error("thirty-six full mask wrong");

  a_x36_low_lanes: assert property (@(posedge hclk) disable iff (!hresetn)
    (org_q == wlm_pkg::ORG_X36 && (pins.bws_n == 4'he || pins.bws_n == 4'hd))
      |-> cur_mask == (pins.bws_n[0] ? 36'h00003fe00 : 36'h0000001ff))
    else $error("thirty-six low lane mask wrong");

  a_x36_high_lanes: assert property (@(posedge hclk) disable iff (!hresetn)
    (org_q == wlm_pkg::ORG_X36 && (pins.bws_n == 4'hb || pins.bws_n == 4'h7))
      |-> cur_mask == (pins.bws_n[2] ? 36'hff8000000 : 36'h007fc0000))
    else $error("thirty-six high lane mask wrong");

  a_x36_none: assert property (@(posedge hclk) disable iff (!hresetn)
    (org_q == wlm_pkg::ORG_X36 && pins.bws_n == 4'hf) |-> cur_mask == '0)
    else $error("thirty-six none mask wrong");

  a_beat_masks_apart: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == wlm_pkg::ST_BEAT1 && neg_rise)
      |=> wmask_q == {$past(cur_mask), $past(lo_mask_q)})
    else $error("beat masks mixed");

  a_outputs_released: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> !rd_bus_oe [*4])
    else $error("data outputs driven after power-up");

endmodule : write_lane_mask
`default_nettype wire

// *** verification/wr_ctrl_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module wr_ctrl_model (
  input  wire logic                         hclk,
  output logic                              input_timing_pos,
  output logic                              input_timing_neg,
  output logic                              wr_port_sel_n,
  output logic [wlm_pkg::ADDR_W-1:0]        wr_addr_in,
  output logic [wlm_pkg::LANES-1:0]         lane_write_select_n,
  output logic [1:0]                        half_lane_write_select_n,
  output logic [wlm_pkg::DATA_W-1:0]        wr_bus_in
);
  // Idle pins: clocks stopped high, port deselected
  initial begin
    input_timing_pos = 1'b1;
    input_timing_neg = 1'b1;
    wr_port_sel_n = 1'b1;
    wr_addr_in = '1;
    lane_write_select_n = '1;
    half_lane_write_select_n = '1;
    wr_bus_in = '1;
  end

  // Two-beat burst, every pin held 4 hclk before each clock rise, 4 hclk after the first and 5 hclk after the second
  task automatic burst(input logic sel_n, input logic [3:0] a, input logic [3:0] s0, input logic [3:0] s1,
                       input logic [35:0] d0, input logic [35:0] d1);
    @(posedge hclk);
    input_timing_pos <= 1'b0;
    input_timing_neg <= 1'b0;
    wr_port_sel_n <= sel_n;
    lane_write_select_n <= s0;
    half_lane_write_select_n <= s0[1:0];
    wr_bus_in <= d0;
    repeat (4) @(posedge hclk);
    input_timing_pos <= 1'b1;
    repeat (4) @(posedge hclk);
    wr_port_sel_n <= 1'b1;
    wr_addr_in <= a;
    lane_write_select_n <= s1;
    half_lane_write_select_n <= s1[1:0];
    wr_bus_in <= d1;
    repeat (4) @(posedge hclk);
    input_timing_neg <= 1'b1;
    repeat (5) @(posedge hclk);
    wr_bus_in <= ~d1; // Beat no longer held
    wr_addr_in <= ~a;
  endtask : burst
endmodule : wr_ctrl_model
`default_nettype wire

// *** verification/write_lane_mask_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module write_lane_mask_tb_top;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_bus_oe, wr_busy;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans, nws_n;
  logic [2:0]  hsize;
  logic        pos, neg, sel_n;
  logic [3:0]  wa, bws_n;
  logic [35:0] wd, d0;
  logic [71:0] shadow, w;
  int          num_errors, checks_done;

  write_lane_mask write_lane_mask_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .input_timing_pos(pos), .input_timing_neg(neg), .wr_port_sel_n(sel_n), .wr_addr_in(wa),
    .lane_write_select_n(bws_n), .half_lane_write_select_n(nws_n), .wr_bus_in(wd), .rd_bus_oe(rd_bus_oe),
    .wr_busy(wr_busy));
  wr_ctrl_model wr_ctrl_model_i (.hclk(hclk), .input_timing_pos(pos), .input_timing_neg(neg),
    .wr_port_sel_n(sel_n), .wr_addr_in(wa), .lane_write_select_n(bws_n), .half_lane_write_select_n(nws_n),
    .wr_bus_in(wd));

  // Clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Compare and count
  task automatic check(input logic [71:0] seen, input logic [71:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // Single AHB-Lite word transfer
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wdat, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wdat;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb

  // Whole 72-bit array word through the read window
  task automatic rd_word(input logic [3:0] a, output logic [71:0] wo);
    logic [31:0] p [4];
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, wlm_pkg::RDADDR_OFF, {26'h0, i[1:0], a}, r);
      ahb(1'b0, wlm_pkg::RDDATA_OFF, 32'h0, p[i]);
    end
    wo = {p[3][3:0], p[2], p[1][3:0], p[0]};
  endtask : rd_word

  // Burst with a look at the busy flag while the second beat is awaited
  task automatic burst_busy(input logic sel_n, input logic [3:0] a, input logic [35:0] d, input logic exp);
    fork
      wr_ctrl_model_i.burst(sel_n, a, 4'h0, 4'h0, d, d);
      begin
        repeat (11) @(posedge hclk);
        check(72'(wr_busy), 72'(exp), "busy mid burst");
      end
    join
  endtask : burst_busy

  // Stored lanes of one beat for an organization and select pattern
  function automatic logic [35:0] lane(input int o, input logic [3:0] s);
    logic [35:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) if (!s[i]) m[9*i +: 9] = 9'h1ff;
    case (o)
      0: m = {28'h0, s[1] ? 4'h0 : 4'hf, s[0] ? 4'h0 : 4'hf};
      1: m = m & 36'h1ff;
      2: m = m & 36'h3ffff;
      default: ;
    endcase
    return m;
  endfunction : lane

  // Reset values, unmapped offset, released read bus
  task automatic test_reset;
    ahb(1'b0, wlm_pkg::CTRL_OFF, 32'h0, r);
    check(72'(r), 72'(32'h7), "ctrl reset");
    ahb(1'b0, wlm_pkg::STATUS_OFF, 32'h0, r);
    check(72'(r), 72'h0, "status reset");
    check(72'(rd_bus_oe), 72'h0, "read bus driven");
    check(72'(hresp), 72'h0, "response");
    ahb(1'b1, 8'h10, 32'hffffffff, r);
    ahb(1'b0, 8'h10, 32'h0, r);
    check(72'(r), 72'h0, "unmapped read");
  endtask : test_reset

  // Every select pattern in every organization, beats differing
  task automatic test_masks;
    logic [35:0] m0, m1, wm;
    for (int o = 0; o < 4; o++) begin
      ahb(1'b1, wlm_pkg::CTRL_OFF, {29'h0, 1'b1, o[1:0]}, r);
      wm = lane(o, 4'h0);
      burst_busy(1'b0, o[3:0], 36'h0, 1'b1);
      shadow = '0;
      for (int s = 0; s < 16; s++) begin
        d0 = {9{s[3:0]}};
        m0 = lane(o, s[3:0]);
        m1 = lane(o, ~s[3:0]);
        wr_ctrl_model_i.burst(1'b0, o[3:0], s[3:0], ~s[3:0], d0, ~d0);
        shadow = (shadow & ~{m1, m0}) | ({~d0, d0} & {m1, m0});
        rd_word(o[3:0], w);
        check(72'(w[35:0] & wm), 72'(shadow[35:0]), "beat0 lanes");
        check(72'(w[71:36] & wm), 72'(shadow[71:36]), "beat1 lanes");
      end
    end
  endtask : test_masks

  // Deselected and disabled bursts leave word and count alone
  task automatic test_refused;
    burst_busy(1'b1, 4'h3, 36'hfffffffff, 1'b0);
    ahb(1'b1, wlm_pkg::CTRL_OFF, 32'h3, r);
    burst_busy(1'b0, 4'h3, 36'hfffffffff, 1'b0);
    rd_word(4'h3, w);
    check(w, shadow, "refused burst wrote");
    ahb(1'b0, wlm_pkg::STATUS_OFF, 32'h0, r);
    check(72'(r[31:16]), 72'd68, "burst count");
    check(72'(wr_busy), 72'h0, "busy after bursts");
  endtask : test_refused

  // Verdict and end of run
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    num_errors = 0;
    checks_done = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    test_reset;
    test_masks;
    test_refused;
    test_done;
  end

  // Watchdog
  initial begin
    repeat (40000) @(posedge hclk);
    num_errors++;
    test_done;
  end
endmodule : write_lane_mask_tb_top
`default_nettype wire
